// ==== bench/tb_top.sv ====
// bench for the channel-3 pin function block
`timescale 1ns/1ns
module tb_top;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        ext_a = 1'b0, ext_c = 1'b0, up = 1'b0, dn = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic        pa_o, pa_oe, pc_o, pc_oe, pin_a, pin_c;
  int          err_count = 0;
  int          check_count = 0;
  int          cyc = 0;
  tio_top i_tio_top (
    .clk_i(clk_i), .rst_i(rst_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .timer_pin_a_i(pin_a), .timer_pin_a_o(pa_o), .timer_pin_a_oe_o(pa_oe),
    .timer_pin_c_i(pin_c), .timer_pin_c_o(pc_o), .timer_pin_c_oe_o(pc_oe),
    .next_cnt_up_i(up), .next_cnt_dn_i(dn), .irq_o(irq));
  tio_pin_model i_tio_pin_model (
    .a_o_i(pa_o), .a_oe_i(pa_oe), .c_o_i(pc_o), .c_oe_i(pc_oe),
    .ext_a_i(ext_a), .ext_c_i(ext_c), .pin_a_o(pin_a), .pin_c_o(pin_c));
  // ----------------------------------------
  // clock, watchdog, shared tasks
  // ----------------------------------------
  always #2 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic cy(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
    @(posedge clk_i);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clk_i);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk("bresp", 32'(r), 32'(bresp));
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = 2'h0);
    @(posedge clk_i);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clk_i);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    chk("rdata", e, rdata);
    chk("rresp", 32'(r), 32'(rresp));
  endtask
  task automatic stim(input int g, input int s);
    @(posedge clk_i);
    if (s < 2 && g == 0) ext_a <= (s == 0);
    if (s < 2 && g == 1) ext_c <= (s == 0);
    up <= (s == 2);
    dn <= (s == 3);
    @(posedge clk_i);
    up <= 1'b0;
    dn <= 1'b0;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
    chk("a_oe", 32'h0, 32'(pa_oe));
    rd(tio_pkg::OFS_IO_HIGH, 32'h0);
    wr(tio_pkg::OFS_IO_HIGH, 32'hF7);
    rd(tio_pkg::OFS_IO_HIGH, 32'h7);
    wr(8'h40, 32'h1, tio_pkg::RESP_SLVERR);
    rd(8'h40, 32'h0, tio_pkg::RESP_SLVERR);
    wr(tio_pkg::OFS_IO_HIGH, 32'h0);
  endtask
  task automatic t_out();
    logic [7:0] io, gr;
    logic       e;
    for (int g = 0; g < 2; g++) begin
      io = g ? tio_pkg::OFS_IO_LOW : tio_pkg::OFS_IO_HIGH;
      gr = g ? tio_pkg::OFS_GRC : tio_pkg::OFS_GRA;
      wr(g ? tio_pkg::OFS_GRA : tio_pkg::OFS_GRC, 32'hFFFF);
      wr(gr, 32'h3);
      for (int c = 0; c < 8; c++) begin
        wr(io, 32'(c));
        cy(1);
        chk("oe", 32'(c[1:0] != 2'h0), 32'(g ? pc_oe : pa_oe));
        if (c[1:0] != 2'h0) chk("init", 32'(c[2]), 32'(g ? pc_o : pa_o));
        for (int k = 1; k < 3; k++) begin
          wr(tio_pkg::OFS_CNT, 32'h0);
          wr(tio_pkg::OFS_MODE, 32'h2);
          cy(12);
          wr(tio_pkg::OFS_MODE, 32'h0);
          e = (c[1:0] == 2'h3) ? c[2] ^ k[0] : c[1];
          if (c[1:0] != 2'h0) chk("level", 32'(e), 32'(g ? pc_o : pa_o));
        end
        rd(tio_pkg::OFS_STAT, g ? 32'h2 : 32'h1);
        wr(tio_pkg::OFS_STAT, 32'h3);
      end
      wr(io, 32'h0);
    end
  endtask
  task automatic t_cap();
    logic [3:0] cd [6] = '{4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hF};
    logic [7:0] io, gr;
    logic       h;
    wr(tio_pkg::OFS_CNT, 32'hA5);
    for (int g = 0; g < 2; g++) begin
      io = g ? tio_pkg::OFS_IO_LOW : tio_pkg::OFS_IO_HIGH;
      gr = g ? tio_pkg::OFS_GRC : tio_pkg::OFS_GRA;
      for (int i = 0; i < 6; i++) begin
        wr(io, 32'(cd[i]));
        for (int s = 0; s < 4; s++) begin
          wr(gr, 32'h0);
          stim(g, s);
          cy(3);
          h = (cd[i][3:2] == 2'h3) ? (s > 1) : (s == 0) ? (cd[i][1] || !cd[i][0])
            : (s == 1) ? (cd[i][1] || cd[i][0]) : 1'b0;
          rd(gr, h ? 32'hA5 : 32'h0);
        end
      end
      wr(io, 32'h0);
    end
    wr(tio_pkg::OFS_STAT, 32'h3);
  endtask
  task automatic t_buf();
    wr(tio_pkg::OFS_MODE, 32'h1);
    wr(tio_pkg::OFS_IO_LOW, 32'h1);
    cy(2);
    chk("c_oe", 32'h0, 32'(pc_oe));
    wr(tio_pkg::OFS_IO_LOW, 32'h8);
    wr(tio_pkg::OFS_GRC, 32'h0);
    stim(1, 0);
    cy(3);
    rd(tio_pkg::OFS_STAT, 32'h0);
    rd(tio_pkg::OFS_GRC, 32'h0);
    stim(1, 1);
    wr(tio_pkg::OFS_IO_LOW, 32'h0);
    wr(tio_pkg::OFS_MODE, 32'h0);
  endtask
  task automatic t_irq();
    wr(tio_pkg::OFS_IO_HIGH, 32'hA);
    wr(tio_pkg::OFS_MASK, 32'h1);
    rd(tio_pkg::OFS_MASK, 32'h1);
    stim(0, 0);
    cy(3);
    chk("irq", 32'h1, 32'(irq));
    wr(tio_pkg::OFS_STAT, 32'h1);
    cy(2);
    chk("irq", 32'h0, 32'(irq));
    wr(tio_pkg::OFS_MASK, 32'h0);
    stim(0, 1);
    cy(3);
    chk("irq", 32'h0, 32'(irq));
    rd(tio_pkg::OFS_STAT, 32'h1);
    wr(tio_pkg::OFS_STAT, 32'h1);
    rd(tio_pkg::OFS_STAT, 32'h0);
  endtask
  initial begin
    cy(2);
    rst_i <= 1'b0;
    t_regs();
    t_out();
    t_cap();
    t_buf();
    t_irq();
    summarize();
  end
endmodule

// ==== bench/tio_pin_model.sv ====
// external circuitry on the two timer pins
`timescale 1ns/1ns
module tio_pin_model (
  // device side
  input  wire logic a_o_i,
  input  wire logic a_oe_i,
  input  wire logic c_o_i,
  input  wire logic c_oe_i,
  // external drivers
  input  wire logic ext_a_i,
  input  wire logic ext_c_i,
  // wire levels
  output logic      pin_a_o,
  output logic      pin_c_o
);
  // device drive wins
  assign pin_a_o = a_oe_i ? a_o_i : ext_a_i;
  assign pin_c_o = c_oe_i ? c_o_i : ext_c_i;
endmodule

// ==== bench/tio_top_assertions.sv ====
// port checks for the channel-3 pin function block
`timescale 1ns/1ns
module tio_top_assertions (
  // clock and reset
  input wire logic                       clk_i,
  input wire logic                       rst_i,
  // axi4-lite
  input wire logic [tio_pkg::ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic                       s_axi_awvalid_i,
  input wire logic                       s_axi_awready_o,
  input wire logic [31:0]                s_axi_wdata_i,
  input wire logic [3:0]                 s_axi_wstrb_i,
  input wire logic                       s_axi_wvalid_i,
  input wire logic                       s_axi_wready_o,
  input wire logic [1:0]                 s_axi_bresp_o,
  input wire logic                       s_axi_bvalid_o,
  input wire logic                       s_axi_bready_i,
  input wire logic                       s_axi_arvalid_i,
  input wire logic                       s_axi_arready_o,
  input wire logic [31:0]                s_axi_rdata_o,
  input wire logic                       s_axi_rvalid_o,
  input wire logic                       s_axi_rready_i,
  // pins and events
  input wire logic                       timer_pin_a_o,
  input wire logic                       timer_pin_a_oe_o,
  input wire logic                       timer_pin_c_oe_o,
  input wire logic                       irq_o
);
  // ----------------------------------------
  // shadow of written control values
  // ----------------------------------------
  logic       wr_hs;
  logic [3:0] code_r;
  logic [1:0] mode_r;
  logic [1:0] mask_r;
  assign wr_hs = s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      code_r <= 4'h0;
      mode_r <= 2'h0;
      mask_r <= 2'h0;
    end else if (wr_hs && s_axi_wstrb_i[0]) begin
      if (s_axi_awaddr_i == tio_pkg::OFS_IO_HIGH) code_r <= s_axi_wdata_i[3:0];
      if (s_axi_awaddr_i == tio_pkg::OFS_MODE) mode_r <= s_axi_wdata_i[1:0];
      if (s_axi_awaddr_i == tio_pkg::OFS_MASK) mask_r <= s_axi_wdata_i[1:0];
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_wr_code;
    wr_hs && s_axi_wstrb_i[0] && s_axi_awaddr_i == tio_pkg::OFS_IO_HIGH
      && !s_axi_wdata_i[3] && !mode_r[1];
  endsequence
  a_write_answer: assert property (wr_hs |-> ##2 s_axi_bvalid_o)
    else $error("late bvalid");
  a_bresp_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i
    |=> s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("bvalid dropped");
  a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("late rvalid");
  a_rdata_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i
    |=> s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("rvalid dropped");
  a_write_block: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("ready while busy");
  a_oe_follows_code: assert property (s_wr_code |-> ##3 timer_pin_a_oe_o == (code_r[1:0] != 2'h0))
    else $error("pin a oe");
  a_init_level: assert property (s_wr_code |-> ##3 (code_r[1:0] == 2'h0 || timer_pin_a_o == code_r[2]))
    else $error("pin a level");
  a_buffer_c_off: assert property (mode_r[0] [*3] |-> !timer_pin_c_oe_o)
    else $error("pin c driven");
  a_irq_masked: assert property ((mask_r == 2'h0) [*4] |-> !irq_o)
    else $error("irq masked");
endmodule
bind tio_top tio_top_assertions i_tio_top_assertions (.*);

// ==== inc/tio_pkg.sv ====
// constants for the channel-3 timer pin function block
package tio_pkg;
  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam int unsigned ADDR_W      = 8;
  localparam logic [7:0]  OFS_IO_HIGH = 8'h00;
  localparam logic [7:0]  OFS_IO_LOW  = 8'h04;
  localparam logic [7:0]  OFS_MODE    = 8'h08;
  localparam logic [7:0]  OFS_CNT     = 8'h0C;
  localparam logic [7:0]  OFS_GRA     = 8'h10;
  localparam logic [7:0]  OFS_GRC     = 8'h14;
  localparam logic [7:0]  OFS_STAT    = 8'h18;
  localparam logic [7:0]  OFS_MASK    = 8'h1C;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int unsigned IO_CAP_BIT  = 3;
  localparam int unsigned IO_INIT_BIT = 2;
  localparam int unsigned IO_CH4_BIT  = 2;
  localparam int unsigned IO_BOTH_BIT = 1;
  localparam int unsigned IO_FALL_BIT = 0;
  localparam int unsigned MODE_BFA    = 0;
  localparam int unsigned MODE_RUN    = 1;
  // ----------------------------------------
  // encodings and reset values
  // ----------------------------------------
  localparam logic [1:0]  ACT_NONE    = 2'h0;
  localparam logic [1:0]  ACT_LOW     = 2'h1;
  localparam logic [1:0]  ACT_HIGH    = 2'h2;
  localparam logic [1:0]  ACT_TOGGLE  = 2'h3;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam logic [3:0]  IO_RST      = 4'h0;
  localparam logic [1:0]  MODE_RST    = 2'h0;
  localparam logic [31:0] WORD_RST    = 32'h0000_0000;
endpackage

// ==== inc/tio_unit_if.sv ====
// link between the register block and one pin function unit
`timescale 1ns/1ns
interface tio_unit_if;
  logic [3:0] code;
  logic       code_wr;
  logic       bypass;
  logic       match;
  logic       pin_in;
  logic       up;
  logic       dn;
  logic       pin_out;
  logic       pin_oe;
  logic       capture;
  logic       evt;
  modport unit (input code, code_wr, bypass, match, pin_in, up, dn,
                output pin_out, pin_oe, capture, evt);
  modport ctrl (output code, code_wr, bypass, match, pin_in, up, dn,
                input pin_out, pin_oe, capture, evt);
endinterface

// ==== rtl/tio_irq.sv ====
// sticky event status with mask and one level interrupt
`timescale 1ns/1ns
module tio_irq #(
  parameter int unsigned N = 2
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // events and software access
  input  wire logic [N-1:0] set_i,
  input  wire logic [N-1:0] clr_i,
  input  wire logic         mask_we_i,
  input  wire logic [N-1:0] mask_d_i,
  // state
  output logic      [N-1:0] status_o,
  output logic      [N-1:0] mask_o,
  output logic              irq_o
);
  logic [N-1:0] status_r;
  logic [N-1:0] mask_r;
  logic         irq_r;

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_bit
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          status_r[g] <= 1'b0;
        end else if (set_i[g]) begin
          status_r[g] <= 1'b1;
        end else if (clr_i[g]) begin
          status_r[g] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_r <= '0;
      irq_r  <= 1'b0;
    end else begin
      if (mask_we_i) begin
        mask_r <= mask_d_i;
      end
      irq_r <= |(status_r & mask_r);
    end
  end

  assign status_o = status_r;
  assign mask_o   = mask_r;
  assign irq_o    = irq_r;
endmodule

// ==== rtl/tio_top.sv ====
// channel-3 timer pin function select with registers on axi4-lite
//
// Contract
// - Codes 0000 and 0100 make the register an output compare with its pin not driven.
// - Codes 0001/0010/0011 start the pin low and drive low, high or toggle on match; 0101/0110/0111 start high.
// - In the toggle codes every compare match inverts the present pin level.
// - With the top code bit set and the next clear, register A captures from its own channel-A pin.
// - Code 1000 captures the counter on each rising edge of the capture pin.
// - Code 1001 captures the counter on each falling edge of the capture pin.
// - Code 101x captures the counter on both edges of the capture pin.
// - Code 11xx takes the capture trigger from the next channel's counting instead of a pin.
// - With next-channel sourcing, each count-up or count-down of that counter causes a capture.
// - Register C uses the same coding as A, on the channel-C pin.
// - When buffer mode makes C a buffer of A, C's code is ignored and C neither captures nor drives.
`timescale 1ns/1ns
module tio_top #(
  parameter int unsigned CW = 16
) (
  // clock and reset
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  // axi4-lite write address
  input  wire logic [tio_pkg::ADDR_W-1:0] s_axi_awaddr_i,
  input  wire logic                       s_axi_awvalid_i,
  output logic                            s_axi_awready_o,
  // axi4-lite write data
  input  wire logic [31:0]                s_axi_wdata_i,
  input  wire logic [3:0]                 s_axi_wstrb_i,
  input  wire logic                       s_axi_wvalid_i,
  output logic                            s_axi_wready_o,
  // axi4-lite write response
  output logic      [1:0]                 s_axi_bresp_o,
  output logic                            s_axi_bvalid_o,
  input  wire logic                       s_axi_bready_i,
  // axi4-lite read address
  input  wire logic [tio_pkg::ADDR_W-1:0] s_axi_araddr_i,
  input  wire logic                       s_axi_arvalid_i,
  output logic                            s_axi_arready_o,
  // axi4-lite read data
  output logic      [31:0]                s_axi_rdata_o,
  output logic      [1:0]                 s_axi_rresp_o,
  output logic                            s_axi_rvalid_o,
  input  wire logic                       s_axi_rready_i,
  // timer pins
  input  wire logic                       timer_pin_a_i,
  output logic                            timer_pin_a_o,
  output logic                            timer_pin_a_oe_o,
  input  wire logic                       timer_pin_c_i,
  output logic                            timer_pin_c_o,
  output logic                            timer_pin_c_oe_o,
  // next channel counting events
  input  wire logic                       next_cnt_up_i,
  input  wire logic                       next_cnt_dn_i,
  // interrupt
  output logic                            irq_o
);
  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic                       awready_r;
  logic                       wready_r;
  logic                       bvalid_r;
  logic [1:0]                 bresp_r;
  logic                       arready_r;
  logic                       rvalid_r;
  logic [1:0]                 rresp_r;
  logic [31:0]                rdata_r;
  logic [tio_pkg::ADDR_W-1:0] awaddr_r;
  logic [31:0]                wdata_r;
  logic [3:0]                 wstrb_r;
  logic [tio_pkg::ADDR_W-1:0] wr_addr;
  logic [31:0]                wmask;
  logic                       wr_fire;
  logic                       wr_map;
  logic [tio_pkg::ADDR_W-1:0] rd_addr;
  logic [31:0]                rd_data;
  logic                       rd_map;
  logic [3:0]                 reg_a_io_code_r;
  logic [3:0]                 reg_c_io_code_r;
  logic                       code_a_wr_r;
  logic                       code_c_wr_r;
  logic [1:0]                 mode_r;
  logic [CW-1:0]              cnt_r;
  logic [CW-1:0]              general_reg_a_r;
  logic [CW-1:0]              general_reg_c_r;
  logic                       buffer_a_select;
  logic                       run;
  logic                       match_a;
  logic                       match_c;
  logic [1:0]                 evt;
  logic [1:0]                 status;
  logic [1:0]                 mask;
  logic                       irq;
  logic                       wr_io_high;
  logic                       wr_io_low;
  logic                       wr_mode;
  logic                       wr_cnt;
  logic                       wr_gra;
  logic                       wr_grc;
  logic                       wr_stat;
  logic                       wr_mask;

  tio_unit_if u_a_if ();
  tio_unit_if u_c_if ();

  // ----------------------------------------
  // write channel
  // ----------------------------------------
  assign wmask   = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
  assign wr_fire = !awready_r && !wready_r && !bvalid_r;
  assign wr_addr = awaddr_r & 8'hFC;

  always_comb begin
    case (wr_addr)
      tio_pkg::OFS_IO_HIGH,
      tio_pkg::OFS_IO_LOW,
      tio_pkg::OFS_MODE,
      tio_pkg::OFS_CNT,
      tio_pkg::OFS_GRA,
      tio_pkg::OFS_GRC,
      tio_pkg::OFS_STAT,
      tio_pkg::OFS_MASK: wr_map = 1'b1;
      default:           wr_map = 1'b0;
    endcase
  end

  assign wr_io_high = wr_fire && (wr_addr == tio_pkg::OFS_IO_HIGH);
  assign wr_io_low  = wr_fire && (wr_addr == tio_pkg::OFS_IO_LOW);
  assign wr_mode    = wr_fire && (wr_addr == tio_pkg::OFS_MODE);
  assign wr_cnt     = wr_fire && (wr_addr == tio_pkg::OFS_CNT);
  assign wr_gra     = wr_fire && (wr_addr == tio_pkg::OFS_GRA);
  assign wr_grc     = wr_fire && (wr_addr == tio_pkg::OFS_GRC);
  assign wr_stat    = wr_fire && (wr_addr == tio_pkg::OFS_STAT);
  assign wr_mask    = wr_fire && (wr_addr == tio_pkg::OFS_MASK);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      awready_r <= 1'b1;
      awaddr_r  <= '0;
    end else if (s_axi_awvalid_i && awready_r) begin
      awready_r <= 1'b0;
      awaddr_r  <= s_axi_awaddr_i;
    end else if (bvalid_r && s_axi_bready_i) begin
      awready_r <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wready_r <= 1'b1;
      wdata_r  <= tio_pkg::WORD_RST;
      wstrb_r  <= 4'h0;
    end else if (s_axi_wvalid_i && wready_r) begin
      wready_r <= 1'b0;
      wdata_r  <= s_axi_wdata_i;
      wstrb_r  <= s_axi_wstrb_i;
    end else if (bvalid_r && s_axi_bready_i) begin
      wready_r <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bvalid_r <= 1'b0;
      bresp_r  <= tio_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r  <= wr_map ? tio_pkg::RESP_OKAY : tio_pkg::RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      bvalid_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // read channel
  // ----------------------------------------
  assign rd_addr = s_axi_araddr_i & 8'hFC;

  always_comb begin
    rd_data = tio_pkg::WORD_RST;
    rd_map  = 1'b1;
    case (rd_addr)
      tio_pkg::OFS_IO_HIGH: rd_data[3:0]    = reg_a_io_code_r;
      tio_pkg::OFS_IO_LOW:  rd_data[3:0]    = reg_c_io_code_r;
      tio_pkg::OFS_MODE:    rd_data[1:0]    = mode_r;
      tio_pkg::OFS_CNT:     rd_data[CW-1:0] = cnt_r;
      tio_pkg::OFS_GRA:     rd_data[CW-1:0] = general_reg_a_r;
      tio_pkg::OFS_GRC:     rd_data[CW-1:0] = general_reg_c_r;
      tio_pkg::OFS_STAT:    rd_data[1:0]    = status;
      tio_pkg::OFS_MASK:    rd_data[1:0]    = mask;
      default:              rd_map          = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rresp_r   <= tio_pkg::RESP_OKAY;
      rdata_r   <= tio_pkg::WORD_RST;
    end else if (s_axi_arvalid_i && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rresp_r   <= rd_map ? tio_pkg::RESP_OKAY : tio_pkg::RESP_SLVERR;
      rdata_r   <= rd_data;
    end else if (rvalid_r && s_axi_rready_i) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
    end
  end

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reg_a_io_code_r <= tio_pkg::IO_RST;
      reg_c_io_code_r <= tio_pkg::IO_RST;
      code_a_wr_r     <= 1'b0;
      code_c_wr_r     <= 1'b0;
    end else begin
      if (wr_io_high) begin
        reg_a_io_code_r <= (reg_a_io_code_r & ~wmask[3:0]) | (wdata_r[3:0] & wmask[3:0]);
      end
      if (wr_io_low) begin
        reg_c_io_code_r <= (reg_c_io_code_r & ~wmask[3:0]) | (wdata_r[3:0] & wmask[3:0]);
      end
      code_a_wr_r <= wr_io_high && wstrb_r[0];
      code_c_wr_r <= wr_io_low && wstrb_r[0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_r <= tio_pkg::MODE_RST;
    end else if (wr_mode) begin
      mode_r <= (mode_r & ~wmask[1:0]) | (wdata_r[1:0] & wmask[1:0]);
    end
  end

  assign buffer_a_select = mode_r[tio_pkg::MODE_BFA];
  assign run             = mode_r[tio_pkg::MODE_RUN];

  // ----------------------------------------
  // counter and compare
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= tio_pkg::WORD_RST[CW-1:0];
    end else if (wr_cnt) begin
      cnt_r <= (cnt_r & ~wmask[CW-1:0]) | (wdata_r[CW-1:0] & wmask[CW-1:0]);
    end else if (run) begin
      cnt_r <= CW'(cnt_r + 1'b1);
    end
  end

  assign match_a = run && (cnt_r == general_reg_a_r);
  assign match_c = run && (cnt_r == general_reg_c_r);

  // ----------------------------------------
  // general registers
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      general_reg_a_r <= tio_pkg::WORD_RST[CW-1:0];
    end else if (u_a_if.capture) begin
      general_reg_a_r <= cnt_r;
    end else if (buffer_a_select && match_a && !reg_a_io_code_r[tio_pkg::IO_CAP_BIT]) begin
      general_reg_a_r <= general_reg_c_r;
    end else if (wr_gra) begin
      general_reg_a_r <= (general_reg_a_r & ~wmask[CW-1:0]) | (wdata_r[CW-1:0] & wmask[CW-1:0]);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      general_reg_c_r <= tio_pkg::WORD_RST[CW-1:0];
    end else if (u_c_if.capture) begin
      general_reg_c_r <= cnt_r;
    end else if (buffer_a_select && u_a_if.capture) begin
      general_reg_c_r <= general_reg_a_r;
    end else if (wr_grc) begin
      general_reg_c_r <= (general_reg_c_r & ~wmask[CW-1:0]) | (wdata_r[CW-1:0] & wmask[CW-1:0]);
    end
  end

  // ----------------------------------------
  // pin function units
  // ----------------------------------------
  assign u_a_if.code    = reg_a_io_code_r;
  assign u_a_if.code_wr = code_a_wr_r;
  assign u_a_if.bypass  = 1'b0;
  assign u_a_if.match   = match_a;
  assign u_a_if.pin_in  = timer_pin_a_i;
  assign u_a_if.up      = next_cnt_up_i;
  assign u_a_if.dn      = next_cnt_dn_i;

  assign u_c_if.code    = reg_c_io_code_r;
  assign u_c_if.code_wr = code_c_wr_r;
  assign u_c_if.bypass  = buffer_a_select;
  assign u_c_if.match   = match_c;
  assign u_c_if.pin_in  = timer_pin_c_i;
  assign u_c_if.up      = next_cnt_up_i;
  assign u_c_if.dn      = next_cnt_dn_i;

  tio_unit u_unit_a (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .u     (u_a_if)
  );

  tio_unit u_unit_c (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .u     (u_c_if)
  );

  // ----------------------------------------
  // interrupt
  // ----------------------------------------
  assign evt = {u_c_if.evt, u_a_if.evt};

  tio_irq #(
    .N (2)
  ) u_irq (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .set_i     (evt),
    .clr_i     (wr_stat ? (wdata_r[1:0] & {2{wstrb_r[0]}}) : 2'h0),
    .mask_we_i (wr_mask && wstrb_r[0]),
    .mask_d_i  (wdata_r[1:0]),
    .status_o  (status),
    .mask_o    (mask),
    .irq_o     (irq)
  );

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign s_axi_awready_o  = awready_r;
  assign s_axi_wready_o   = wready_r;
  assign s_axi_bvalid_o   = bvalid_r;
  assign s_axi_bresp_o    = bresp_r;
  assign s_axi_arready_o  = arready_r;
  assign s_axi_rvalid_o   = rvalid_r;
  assign s_axi_rresp_o    = rresp_r;
  assign s_axi_rdata_o    = rdata_r;
  assign timer_pin_a_o    = u_a_if.pin_out;
  assign timer_pin_a_oe_o = u_a_if.pin_oe;
  assign timer_pin_c_o    = u_c_if.pin_out;
  assign timer_pin_c_oe_o = u_c_if.pin_oe;
  assign irq_o            = irq;
endmodule

// ==== rtl/tio_unit.sv ====
// pin function unit: compare output or capture trigger for one register
`timescale 1ns/1ns
module tio_unit (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control side
  tio_unit_if.unit u
);
  logic prev_r;
  logic level_r;
  logic oe_r;
  logic rise;
  logic fall;
  logic cap_sel;
  logic is_out;

  assign rise   = u.pin_in & ~prev_r;
  assign fall   = ~u.pin_in & prev_r;
  assign is_out = !u.bypass && !u.code[tio_pkg::IO_CAP_BIT];

  always_comb begin
    cap_sel = 1'b0;
    if (u.code[tio_pkg::IO_CH4_BIT]) begin
      cap_sel = u.up | u.dn;
    end else if (u.code[tio_pkg::IO_BOTH_BIT]) begin
      cap_sel = rise | fall;
    end else if (u.code[tio_pkg::IO_FALL_BIT]) begin
      cap_sel = fall;
    end else begin
      cap_sel = rise;
    end
  end

  assign u.capture = !u.bypass && u.code[tio_pkg::IO_CAP_BIT] && cap_sel;
  assign u.evt     = u.capture | (is_out && u.match);
  assign u.pin_out = level_r;
  assign u.pin_oe  = oe_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= u.pin_in;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      oe_r <= 1'b0;
    end else begin
      oe_r <= is_out && (u.code[1:0] != tio_pkg::ACT_NONE);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      level_r <= 1'b0;
    end else if (u.code_wr && !u.code[tio_pkg::IO_CAP_BIT]) begin
      level_r <= u.code[tio_pkg::IO_INIT_BIT];
    end else if (is_out && u.match) begin
      case (u.code[1:0])
        tio_pkg::ACT_LOW:    level_r <= 1'b0;
        tio_pkg::ACT_HIGH:   level_r <= 1'b1;
        tio_pkg::ACT_TOGGLE: level_r <= ~level_r;
        default:             level_r <= level_r;
      endcase
    end
  end
endmodule
